// ==== rtl/rsl_logger.sv ====
`timescale 1ns/1ps
module rsl_logger
#(
	parameter int unsigned SEC_CYCLES  = rsl_pkg::SEC_CYCLES,
	parameter int unsigned FLASH_WORDS = rsl_pkg::FLASH_WORDS
)
(
	// clock and reset
	input  wire logic                         CLK_I,
	input  wire logic                         RST_N_I,
	// register access
	input  wire rsl_pkg::rsl_reg_req_t        REG_REQ_I,
	output rsl_pkg::rsl_reg_rsp_t             REG_RSP_O,
	// meter register reads
	output rsl_pkg::rsl_meter_req_t           METER_O,
	input  wire logic                         METER_ACK_I,
	input  wire logic [15:0]                  METER_DATA_I,
	// flash writes
	output rsl_pkg::rsl_flash_t               FLASH_O,
	input  wire logic                         FLASH_ACK_I
);
	localparam int unsigned NB = rsl_pkg::NUM_BLOCKS;
	localparam int unsigned AW = rsl_pkg::FLASH_AW;
	localparam logic [24:0] PRESC_LAST = 25'(SEC_CYCLES - 1);
	localparam logic [AW-1:0] PTR_LAST = AW'(FLASH_WORDS - 1);
	localparam logic [3:0] BLK_LAST = 4'(NB - 1);

	typedef struct packed {
		rsl_pkg::rsl_mode_t     mode;
		logic [15:0]            interval;
		logic [NB-1:0][15:0]    blk_start;
		logic [NB-1:0][6:0]     blk_cnt;
		logic [31:0]            seconds;
		logic [15:0]            clk_hi_pend;
		logic [15:0]            rd_lo_shadow;
		logic [24:0]            presc;
		logic [15:0]            ivl_cnt;
		logic                   trig_pend;
		logic                   stored;
		logic                   full;
		logic                   wrapped;
		logic [AW-1:0]          ptr;
		rsl_pkg::rsl_samp_t     samp;
		logic [31:0]            ts;
		logic [3:0]             blk;
		logic [6:0]             idx;
		logic [15:0]            word;
		rsl_pkg::rsl_meter_req_t mtr;
		rsl_pkg::rsl_flash_t    fl;
		rsl_pkg::rsl_reg_rsp_t  rsp;
	} rsl_core_st_t;

	localparam rsl_core_st_t ST_RST = '{
		mode:         rsl_pkg::MODE_DISABLED,
		interval:     rsl_pkg::INTERVAL_RST,
		seconds:      rsl_pkg::SECONDS_RST,
		samp:         rsl_pkg::SAMP_IDLE,
		default:      '0
	};

	rsl_core_st_t s_ff;
	rsl_core_st_t nxt_s;

	logic        fifo_in_valid;
	logic [15:0] fifo_in_data;
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	logic [15:0] fifo_out_data;
	logic        fifo_out_ready;

	logic        sec_tick;
	logic        ivl_hit;
	logic        cfg_unlocked;
	logic        erase_ok;
	logic [5:0]  bh;
	logic [15:0] mode_max;

	// decodes a block register: {hit, block index, count select}
	function automatic logic [5:0] blk_decode(input logic [15:0] addr);
		logic [15:0] off;
		off = 16'(addr - rsl_pkg::REG_BLK_BASE);
		if ((addr >= rsl_pkg::REG_BLK_BASE) && (off < rsl_pkg::REG_BLK_SPAN))
		begin
			blk_decode = {1'b1, off[4:1], off[0]};
		end
		else
		begin
			blk_decode = '0;
		end
	endfunction

	rsl_fifo #(
		.WIDTH (rsl_pkg::WORD_W),
		.DEPTH (rsl_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i       (CLK_I),
		.rst_n_i     (RST_N_I),
		.in_valid_i  (fifo_in_valid),
		.in_data_i   (fifo_in_data),
		.in_ready_o  (fifo_in_ready),
		.out_valid_o (fifo_out_valid),
		.out_data_o  (fifo_out_data),
		.out_ready_i (fifo_out_ready)
	);

	// the flash stage holds one word until the flash acknowledges it
	assign fifo_out_ready = !s_ff.fl.wr;

	always_comb
	begin
		fifo_in_valid = 1'b0;
		fifo_in_data = s_ff.word;
		case (s_ff.samp)
			rsl_pkg::SAMP_TS_HI:
			begin
				fifo_in_valid = 1'b1;
				fifo_in_data = s_ff.ts[31:16];
			end
			rsl_pkg::SAMP_TS_LO:
			begin
				fifo_in_valid = 1'b1;
				fifo_in_data = s_ff.ts[15:0];
			end
			rsl_pkg::SAMP_PUSH:
			begin
				fifo_in_valid = 1'b1;
			end
			default:
			begin
				fifo_in_valid = 1'b0;
			end
		endcase
	end

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.rsp.ack = 1'b0;
		nxt_s.rsp.err = 1'b0;
		nxt_s.fl.erase = 1'b0;
		mode_max = {14'h0000, rsl_pkg::MODE_UNTIL_FULL};
		// lock on mode and stored log
		cfg_unlocked = (s_ff.mode == rsl_pkg::MODE_DISABLED) && !s_ff.stored;
		erase_ok = (s_ff.mode == rsl_pkg::MODE_DISABLED) && (s_ff.samp == rsl_pkg::SAMP_IDLE)
			&& !fifo_out_valid && !s_ff.fl.wr;
		bh = blk_decode(REG_REQ_I.addr);

		sec_tick = (s_ff.presc == PRESC_LAST);
		// a tick that starts a new interval this very cycle
		ivl_hit = sec_tick && (s_ff.mode != rsl_pkg::MODE_DISABLED) && (16'(s_ff.ivl_cnt + 1'b1) >= s_ff.interval);
		if (sec_tick)
		begin
			nxt_s.presc = '0;
			nxt_s.seconds = 32'(s_ff.seconds + 1'b1);
		end
		else
		begin
			nxt_s.presc = 25'(s_ff.presc + 1'b1);
		end

		// interval counted in whole clock seconds
		if (sec_tick && (s_ff.mode != rsl_pkg::MODE_DISABLED))
		begin
			if (16'(s_ff.ivl_cnt + 1'b1) >= s_ff.interval)
			begin
				nxt_s.ivl_cnt = '0;
				nxt_s.trig_pend = 1'b1;
			end
			else
			begin
				nxt_s.ivl_cnt = 16'(s_ff.ivl_cnt + 1'b1);
			end
		end

		// entry sampler
		case (s_ff.samp)
			rsl_pkg::SAMP_IDLE:
			begin
				if (s_ff.trig_pend && (s_ff.mode != rsl_pkg::MODE_DISABLED) && !s_ff.full)
				begin
					// consume the trigger, keep only one raised in this same cycle
					nxt_s.trig_pend = ivl_hit;
					nxt_s.ts = s_ff.seconds;
					nxt_s.blk = '0;
					nxt_s.samp = rsl_pkg::SAMP_TS_HI;
				end
			end
			rsl_pkg::SAMP_TS_HI:
			begin
				if (fifo_in_ready)
				begin
					nxt_s.samp = rsl_pkg::SAMP_TS_LO;
				end
			end
			rsl_pkg::SAMP_TS_LO:
			begin
				if (fifo_in_ready)
				begin
					nxt_s.samp = rsl_pkg::SAMP_BLK;
				end
			end
			// walk all sixteen blocks in order
			rsl_pkg::SAMP_BLK:
			begin
				if (s_ff.blk_cnt[s_ff.blk] == '0)
				begin
					nxt_s.blk = 4'(s_ff.blk + 1'b1);
					if (s_ff.blk == BLK_LAST)
					begin
						nxt_s.samp = rsl_pkg::SAMP_IDLE;
					end
				end
				else
				begin
					nxt_s.idx = '0;
					nxt_s.mtr.req = 1'b1;
					nxt_s.mtr.addr = s_ff.blk_start[s_ff.blk];
					nxt_s.samp = rsl_pkg::SAMP_WAIT;
				end
			end
			rsl_pkg::SAMP_WAIT:
			begin
				if (METER_ACK_I)
				begin
					nxt_s.mtr.req = 1'b0;
					nxt_s.word = METER_DATA_I;
					nxt_s.samp = rsl_pkg::SAMP_PUSH;
				end
			end
			rsl_pkg::SAMP_PUSH:
			begin
				if (fifo_in_ready)
				begin
					if (7'(s_ff.idx + 1'b1) == s_ff.blk_cnt[s_ff.blk])
					begin
						nxt_s.blk = 4'(s_ff.blk + 1'b1);
						nxt_s.samp = (s_ff.blk == BLK_LAST) ? rsl_pkg::SAMP_IDLE : rsl_pkg::SAMP_BLK;
					end
					else
					begin
						nxt_s.idx = 7'(s_ff.idx + 1'b1);
						nxt_s.mtr.req = 1'b1;
						nxt_s.mtr.addr = 16'(s_ff.blk_start[s_ff.blk] + {9'h000, s_ff.idx} + 16'h0001);
						nxt_s.samp = rsl_pkg::SAMP_WAIT;
					end
				end
			end
			default:
			begin
				nxt_s.samp = rsl_pkg::SAMP_IDLE;
			end
		endcase
		// a trigger that lands while full is dropped, not queued
		if ((s_ff.samp == rsl_pkg::SAMP_IDLE) && s_ff.full)
		begin
			nxt_s.trig_pend = 1'b0;
		end

		// flash stage
		if (!s_ff.fl.wr && fifo_out_valid && !s_ff.full)
		begin
			nxt_s.fl.wr = 1'b1;
			nxt_s.fl.addr = s_ff.ptr;
			nxt_s.fl.data = fifo_out_data;
		end
		if (s_ff.fl.wr && FLASH_ACK_I)
		begin
			nxt_s.fl.wr = 1'b0;
			nxt_s.stored = 1'b1;
			if (s_ff.ptr != PTR_LAST)
			begin
				nxt_s.ptr = AW'(s_ff.ptr + 1'b1);
			end
			else if (s_ff.mode == rsl_pkg::MODE_UNTIL_FULL)
			begin
				// stop and fall back to disabled
				nxt_s.full = 1'b1;
				nxt_s.mode = rsl_pkg::MODE_DISABLED;
			end
			else
			begin
				nxt_s.ptr = '0;
				nxt_s.wrapped = 1'b1;
			end
		end

		// register writes
		if (REG_REQ_I.wr)
		begin
			nxt_s.rsp.ack = 1'b1;
			if (REG_REQ_I.addr == rsl_pkg::REG_CLK_HI)
			begin
				// upper half waits for the lower half
				nxt_s.clk_hi_pend = REG_REQ_I.wdata;
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_CLK_LO)
			begin
				// both halves land as one value
				nxt_s.seconds = {s_ff.clk_hi_pend, REG_REQ_I.wdata};
				nxt_s.presc = '0;
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_MODE)
			begin
				if (REG_REQ_I.wdata > mode_max)
				begin
					nxt_s.rsp.ack = 1'b0;
					nxt_s.rsp.err = 1'b1;
				end
				else
				begin
					nxt_s.mode = rsl_pkg::rsl_mode_t'(REG_REQ_I.wdata[1:0]);
					if ((s_ff.mode == rsl_pkg::MODE_DISABLED) && (REG_REQ_I.wdata[1:0] != 2'b00))
					begin
						nxt_s.trig_pend = 1'b1;
						nxt_s.ivl_cnt = '0;
					end
					// next-state full, so a fill landing in this cycle is not lost
					if (nxt_s.full && (REG_REQ_I.wdata[1:0] == rsl_pkg::MODE_CONTINUOUS))
					begin
						nxt_s.full = 1'b0;
						nxt_s.ptr = '0;
						nxt_s.wrapped = 1'b1;
					end
					else if (nxt_s.full && (REG_REQ_I.wdata[1:0] == rsl_pkg::MODE_UNTIL_FULL))
					begin
						nxt_s.mode = rsl_pkg::MODE_DISABLED;
					end
				end
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_INTERVAL)
			begin
				if ((s_ff.mode == rsl_pkg::MODE_DISABLED) && (REG_REQ_I.wdata >= rsl_pkg::INTERVAL_MIN)
					&& (REG_REQ_I.wdata <= rsl_pkg::INTERVAL_MAX))
				begin
					nxt_s.interval = REG_REQ_I.wdata;
					nxt_s.ivl_cnt = '0;
				end
				else
				begin
					nxt_s.rsp.ack = 1'b0;
					nxt_s.rsp.err = 1'b1;
				end
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_ERASE)
			begin
				// pointer back to the first word
				if (erase_ok)
				begin
					nxt_s.ptr = '0;
					nxt_s.stored = 1'b0;
					nxt_s.full = 1'b0;
					nxt_s.wrapped = 1'b0;
					nxt_s.fl.erase = 1'b1;
				end
				else
				begin
					nxt_s.rsp.ack = 1'b0;
					nxt_s.rsp.err = 1'b1;
				end
			end
			else if (bh[5])
			begin
				if (!cfg_unlocked || (bh[0] && (REG_REQ_I.wdata > {9'h000, rsl_pkg::MAX_BLK_REGS})))
				begin
					nxt_s.rsp.ack = 1'b0;
					nxt_s.rsp.err = 1'b1;
				end
				else if (bh[0])
				begin
					nxt_s.blk_cnt[bh[4:1]] = REG_REQ_I.wdata[6:0];
				end
				else
				begin
					nxt_s.blk_start[bh[4:1]] = REG_REQ_I.wdata;
				end
			end
			else
			begin
				nxt_s.rsp.ack = 1'b0;
				nxt_s.rsp.err = 1'b1;
			end
		end
		// register reads
		else if (REG_REQ_I.rd)
		begin
			nxt_s.rsp.ack = 1'b1;
			nxt_s.rsp.rdata = '0;
			if (REG_REQ_I.addr == rsl_pkg::REG_CLK_HI)
			begin
				// lower half frozen so a pair of reads agrees
				nxt_s.rsp.rdata = s_ff.seconds[31:16];
				nxt_s.rd_lo_shadow = s_ff.seconds[15:0];
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_CLK_LO)
			begin
				nxt_s.rsp.rdata = s_ff.rd_lo_shadow;
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_MODE)
			begin
				nxt_s.rsp.rdata = {14'h0000, s_ff.mode};
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_INTERVAL)
			begin
				nxt_s.rsp.rdata = s_ff.interval;
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_STATUS)
			begin
				nxt_s.rsp.rdata[rsl_pkg::STAT_LOGGING] = (s_ff.mode != rsl_pkg::MODE_DISABLED);
				nxt_s.rsp.rdata[rsl_pkg::STAT_STORED] = s_ff.stored;
				nxt_s.rsp.rdata[rsl_pkg::STAT_FULL] = s_ff.full;
				nxt_s.rsp.rdata[rsl_pkg::STAT_WRAPPED] = s_ff.wrapped;
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_ERASE)
			begin
				nxt_s.rsp.rdata = '0;
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_PTR_HI)
			begin
				nxt_s.rsp.rdata = {12'h000, s_ff.ptr[19:16]};
			end
			else if (REG_REQ_I.addr == rsl_pkg::REG_PTR_LO)
			begin
				nxt_s.rsp.rdata = s_ff.ptr[15:0];
			end
			else if (bh[5])
			begin
				nxt_s.rsp.rdata = bh[0] ? {9'h000, s_ff.blk_cnt[bh[4:1]]} : s_ff.blk_start[bh[4:1]];
			end
			else
			begin
				nxt_s.rsp.ack = 1'b0;
				nxt_s.rsp.err = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			s_ff <= ST_RST;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	assign REG_RSP_O = s_ff.rsp;
	assign METER_O   = s_ff.mtr;
	assign FLASH_O   = s_ff.fl;
endmodule

// ==== pkg/rsl_pkg.sv ====
package rsl_pkg;
	// timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SECOND_NS     = 1000000000;
	localparam int unsigned SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;

	// log storage, 16-bit words
	localparam int unsigned FLASH_BYTES = 2097152;
	localparam int unsigned FLASH_WORDS = FLASH_BYTES / 2;
	localparam int unsigned FLASH_AW    = 20;
	localparam int unsigned WORD_W      = 16;
	localparam int unsigned FIFO_DEPTH  = 16;
	localparam int unsigned NUM_BLOCKS  = 16;

	// limits and reset values
	localparam logic [6:0]  MAX_BLK_REGS = 7'h7d;
	localparam logic [15:0] INTERVAL_MIN = 16'h0001;
	localparam logic [15:0] INTERVAL_MAX = 16'hfd20;
	localparam logic [15:0] INTERVAL_RST = 16'h0001;
	localparam logic [31:0] SECONDS_RST  = 32'h0000_0000;

	// register offsets
	localparam logic [15:0] REG_CLK_HI   = 16'h4008;
	localparam logic [15:0] REG_CLK_LO   = 16'h4009;
	localparam logic [15:0] REG_MODE     = 16'h4030;
	localparam logic [15:0] REG_INTERVAL = 16'h4031;
	localparam logic [15:0] REG_STATUS   = 16'h4032;
	localparam logic [15:0] REG_ERASE    = 16'h4033;
	localparam logic [15:0] REG_PTR_HI   = 16'h4034;
	localparam logic [15:0] REG_PTR_LO   = 16'h4035;
	localparam logic [15:0] REG_BLK_BASE = 16'h4040;
	localparam logic [15:0] REG_BLK_SPAN = 16'h0020;

	// status bit positions
	localparam int unsigned STAT_LOGGING = 0;
	localparam int unsigned STAT_STORED  = 1;
	localparam int unsigned STAT_FULL    = 2;
	localparam int unsigned STAT_WRAPPED = 3;

	typedef enum logic [1:0] {
		MODE_DISABLED   = 2'b00,
		MODE_CONTINUOUS = 2'b01,
		MODE_UNTIL_FULL = 2'b10
	} rsl_mode_t;

	typedef enum logic [2:0] {
		SAMP_IDLE  = 3'b000,
		SAMP_TS_HI = 3'b001,
		SAMP_TS_LO = 3'b010,
		SAMP_BLK   = 3'b011,
		SAMP_WAIT  = 3'b100,
		SAMP_PUSH  = 3'b101
	} rsl_samp_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} rsl_reg_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [15:0] rdata;
	} rsl_reg_rsp_t;

	typedef struct packed {
		logic                wr;
		logic                erase;
		logic [FLASH_AW-1:0] addr;
		logic [WORD_W-1:0]   data;
	} rsl_flash_t;

	typedef struct packed {
		logic        req;
		logic [15:0] addr;
	} rsl_meter_req_t;
endpackage

// ==== rtl/rsl_fifo.sv ====
`timescale 1ns/1ps
module rsl_fifo
#(
	parameter int unsigned WIDTH = rsl_pkg::WORD_W,
	parameter int unsigned DEPTH = rsl_pkg::FIFO_DEPTH
)
(
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// filling side
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	// draining side
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
		logic                        out_valid;
		logic [WIDTH-1:0]            out_data;
	} rsl_fifo_st_t;

	rsl_fifo_st_t s_ff;
	rsl_fifo_st_t nxt_s;
	logic         push;
	logic         pop;

	// depth must be a power of two so the pointers wrap by themselves
	always_comb
	begin
		nxt_s = s_ff;
		push = in_valid_i && (s_ff.cnt < FULL_CNT);
		pop = (s_ff.cnt != '0) && (!s_ff.out_valid || out_ready_i);
		if (out_ready_i)
		begin
			nxt_s.out_valid = 1'b0;
		end
		if (pop)
		begin
			nxt_s.out_data = s_ff.mem[s_ff.rd];
			nxt_s.out_valid = 1'b1;
			nxt_s.rd = AW'(s_ff.rd + 1'b1);
		end
		if (push)
		begin
			nxt_s.mem[s_ff.wr] = in_data_i;
			nxt_s.wr = AW'(s_ff.wr + 1'b1);
		end
		nxt_s.cnt = (AW+1)'(s_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_ff <= '0;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	assign in_ready_o  = (s_ff.cnt < FULL_CNT);
	assign out_valid_o = s_ff.out_valid;
	assign out_data_o  = s_ff.out_data;
endmodule

// ==== verif/rsl_logger_sva.sv ====
`timescale 1ns/1ps
module rsl_logger_chk
#(
	parameter int unsigned SEC_CYCLES  = 20,
	parameter int unsigned FLASH_WORDS = 16
)
(
	// clock and reset
	input wire logic                   CLK_I,
	input wire logic                   RST_N_I,
	// register access
	input wire rsl_pkg::rsl_reg_req_t  REG_REQ_I,
	input wire rsl_pkg::rsl_reg_rsp_t  REG_RSP_O,
	// meter side
	input wire rsl_pkg::rsl_meter_req_t METER_O,
	input wire logic                   METER_ACK_I,
	input wire logic [15:0]            METER_DATA_I,
	// flash side
	input wire rsl_pkg::rsl_flash_t    FLASH_O,
	input wire logic                   FLASH_ACK_I
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	logic [19:0] exp_addr_ff;
	logic [19:0] nxt_exp_addr;
	logic        req_any;
	logic        blk_cnt;

	assign req_any = REG_REQ_I.wr || REG_REQ_I.rd;
	assign blk_cnt = (REG_REQ_I.addr[15:5] == 11'h202) && REG_REQ_I.addr[0];

	// next flash word address expected: erase or wrap brings it back to zero
	always_comb
	begin
		nxt_exp_addr = exp_addr_ff;
		if (FLASH_O.erase)
			nxt_exp_addr = 20'h00000;
		else if (FLASH_O.wr && FLASH_ACK_I)
			nxt_exp_addr = (FLASH_O.addr == 20'(FLASH_WORDS - 1)) ? 20'h00000 : FLASH_O.addr + 20'h00001;
	end

	always_ff @(posedge CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			exp_addr_ff <= 20'h00000;
		else
			exp_addr_ff <= nxt_exp_addr;
	end

	a_resp_exactly_one: assert property (req_any |=> (REG_RSP_O.ack != REG_RSP_O.err))
		else $error("register request without single answer");
	a_resp_never_idle: assert property (!req_any |=> !(REG_RSP_O.ack || REG_RSP_O.err))
		else $error("register answer without request");
	a_clock_hi_ok: assert property (REG_REQ_I.wr && REG_REQ_I.addr == rsl_pkg::REG_CLK_HI |=> REG_RSP_O.ack)
		else $error("clock upper half write refused");
	a_interval_range: assert property (REG_REQ_I.wr && REG_REQ_I.addr == rsl_pkg::REG_INTERVAL &&
		(REG_REQ_I.wdata == 16'h0000 || REG_REQ_I.wdata > 16'hfd20) |=> REG_RSP_O.err)
		else $error("interval out of range accepted");
	a_block_count_max: assert property (REG_REQ_I.wr && blk_cnt && REG_REQ_I.wdata > 16'h007d |=> REG_RSP_O.err)
		else $error("block count above limit accepted");
	a_mode_code_bad: assert property (REG_REQ_I.wr && REG_REQ_I.addr == rsl_pkg::REG_MODE &&
		REG_REQ_I.wdata > 16'h0002 |=> REG_RSP_O.err)
		else $error("unknown mode accepted");
	a_flash_write_hold: assert property (FLASH_O.wr && !FLASH_ACK_I |=>
		FLASH_O.wr && $stable(FLASH_O.addr) && $stable(FLASH_O.data))
		else $error("flash write dropped or changed before done");
	a_flash_addr_seq: assert property (FLASH_O.wr |-> FLASH_O.addr == exp_addr_ff)
		else $error("flash word address out of sequence");
	a_meter_req_hold: assert property (METER_O.req && !METER_ACK_I |=> METER_O.req && $stable(METER_O.addr))
		else $error("meter request dropped or moved before answer");
	a_meter_req_drop: assert property (METER_O.req && METER_ACK_I |=> !METER_O.req)
		else $error("meter request held after answer");
endmodule

bind rsl_logger rsl_logger_chk #(.SEC_CYCLES(SEC_CYCLES), .FLASH_WORDS(FLASH_WORDS)) u_chk (.CLK_I(CLK_I),
	.RST_N_I(RST_N_I), .REG_REQ_I(REG_REQ_I), .REG_RSP_O(REG_RSP_O), .METER_O(METER_O), .METER_ACK_I(METER_ACK_I),
	.METER_DATA_I(METER_DATA_I), .FLASH_O(FLASH_O), .FLASH_ACK_I(FLASH_ACK_I));

// ==== verif/rsl_far_model.sv ====
`timescale 1ns/1ps
module rsl_far_model
#(
	parameter int unsigned WORDS = 16
)
(
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	// meter registers
	input  wire rsl_pkg::rsl_meter_req_t meter_i,
	output logic                         meter_ack_o,
	output logic [15:0]                  meter_data_o,
	// flash
	input  wire rsl_pkg::rsl_flash_t     flash_i,
	output logic                         flash_ack_o,
	// answer delay in cycles
	input  wire logic [3:0]              dly_i
);
	logic [15:0] mem [0:WORDS-1];
	logic [3:0]  mcnt;
	logic [3:0]  fcnt;

	// data toggles outside answers so a stale sample never looks right
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meter_ack_o <= 1'b0;
			meter_data_o <= 16'h0000;
			flash_ack_o <= 1'b0;
			mcnt <= 4'h0;
			fcnt <= 4'h0;
		end
		else
		begin
			meter_ack_o <= 1'b0;
			flash_ack_o <= 1'b0;
			meter_data_o <= ~meter_data_o;
			if (meter_i.req && !meter_ack_o)
			begin
				mcnt <= (mcnt == dly_i) ? 4'h0 : mcnt + 4'h1;
				if (mcnt == dly_i)
				begin
					meter_ack_o <= 1'b1;
					meter_data_o <= meter_i.addr ^ 16'hc3a5;
				end
			end
			if (flash_i.wr && !flash_ack_o)
			begin
				fcnt <= (fcnt == dly_i) ? 4'h0 : fcnt + 4'h1;
				flash_ack_o <= (fcnt == dly_i);
			end
			if (flash_i.wr && flash_ack_o)
				mem[flash_i.addr] <= flash_i.data;
			if (flash_i.erase)
				for (int i = 0; i < WORDS; i++)
					mem[i] <= 16'hffff;
		end
	end
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
	logic                    CLK_I;
	logic                    RST_N_I;
	rsl_pkg::rsl_reg_req_t   req;
	rsl_pkg::rsl_reg_rsp_t   rsp;
	rsl_pkg::rsl_meter_req_t meter;
	rsl_pkg::rsl_flash_t     flash;
	logic                    m_ack;
	logic [15:0]             m_data;
	logic                    f_ack;
	logic [3:0]              dly;
	logic [15:0]             rd;
	logic [1:0]              e;
	int                      err_count;
	int                      samples_checked;
	int                      nwr;
	localparam logic [15:0]  BLK = rsl_pkg::REG_BLK_BASE;

	rsl_logger #(.SEC_CYCLES(20), .FLASH_WORDS(16)) dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_REQ_I(req),
		.REG_RSP_O(rsp), .METER_O(meter), .METER_ACK_I(m_ack), .METER_DATA_I(m_data), .FLASH_O(flash),
		.FLASH_ACK_I(f_ack));
	rsl_far_model #(.WORDS(16)) u_far (.clk_i(CLK_I), .rst_n_i(RST_N_I), .meter_i(meter), .meter_ack_o(m_ack),
		.meter_data_o(m_data), .flash_i(flash), .flash_ack_o(f_ack), .dly_i(dly));

	initial
	begin
		CLK_I = 1'b0;
		forever #25 CLK_I = ~CLK_I;
	end

	always @(posedge CLK_I)
		if (flash.wr && f_ack)
			nwr++;

	function automatic logic [15:0] mval(input logic [15:0] a);
		return a ^ 16'hc3a5;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(negedge CLK_I);
		req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge CLK_I);
		// ack and err stand for one cycle only: take them now
		rd = rsp.rdata;
		e = {rsp.ack, rsp.err};
		req.wr = 1'b0;
		req.rd = 1'b0;
		@(negedge CLK_I);
	endtask

	task automatic wreg(input logic [15:0] a, input logic [15:0] d, input logic exp_err);
		acc(1'b1, a, d);
		chk({14'h0000, e}, {14'h0000, !exp_err, exp_err});
	endtask

	task automatic rreg(input logic [15:0] a, input logic [15:0] exp);
		acc(1'b0, a, 16'h0000);
		chk({14'h0000, e}, 16'h0002);
		chk(rd, exp);
	endtask

	task automatic wait_wr(input int n);
		for (int i = 0; i < 4000 && nwr < n; i++)
			@(negedge CLK_I);
		chk({15'h0000, nwr >= n}, 16'h0001);
	endtask

	task automatic final_report;
		$display("mismatches %0d comparisons %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// generous: the sequence needs well under a thousand cycles, the limit is 20000
	initial
	begin
		#1000000;
		err_count++;
		final_report;
	end

	initial
	begin
		req = '0;
		dly = 4'h0;
		RST_N_I = 1'b0;
		repeat (12) @(negedge CLK_I);
		RST_N_I = 1'b1;
		rreg(rsl_pkg::REG_CLK_HI, 16'h0000);
		acc(1'b0, 16'h4100, 16'h0000);
		chk({14'h0000, e}, 16'h0001);
		wreg(rsl_pkg::REG_CLK_HI, 16'h1234, 1'b0);
		wreg(rsl_pkg::REG_CLK_LO, 16'hffff, 1'b0);
		rreg(rsl_pkg::REG_CLK_HI, 16'h1234);
		rreg(rsl_pkg::REG_CLK_LO, 16'hffff);
		wreg(rsl_pkg::REG_CLK_HI, 16'h0bad, 1'b0);
		rreg(rsl_pkg::REG_CLK_HI, 16'h1234);
		repeat (10) @(negedge CLK_I);
		rreg(rsl_pkg::REG_CLK_HI, 16'h1235);
		rreg(rsl_pkg::REG_CLK_LO, 16'h0000);
		wreg(rsl_pkg::REG_INTERVAL, 16'h0000, 1'b1);
		wreg(rsl_pkg::REG_INTERVAL, 16'hfd21, 1'b1);
		wreg(rsl_pkg::REG_INTERVAL, 16'hfd20, 1'b0);
		rreg(rsl_pkg::REG_INTERVAL, 16'hfd20);
		wreg(rsl_pkg::REG_INTERVAL, 16'h0001, 1'b0);
		wreg(rsl_pkg::REG_MODE, 16'h0003, 1'b1);
		wreg(BLK + 16'h0001, 16'h007e, 1'b1);
		wreg(BLK + 16'h0001, 16'h007d, 1'b0);
		wreg(BLK, 16'h0200, 1'b0);
		wreg(BLK + 16'h0001, 16'h0002, 1'b0);
		wreg(BLK + 16'h0006, 16'h1100, 1'b0);
		wreg(BLK + 16'h0007, 16'h0001, 1'b0);
		// continuous: five words per entry, so entry four wraps the sixteen words
		nwr = 0;
		wreg(rsl_pkg::REG_MODE, 16'h0001, 1'b0);
		wreg(rsl_pkg::REG_INTERVAL, 16'h0002, 1'b1);
		wreg(rsl_pkg::REG_ERASE, 16'h0000, 1'b1);
		wreg(BLK, 16'h0300, 1'b1);
		wait_wr(20);
		chk(u_far.mem[1], mval(16'h0200));
		chk(u_far.mem[2], mval(16'h0201));
		chk(u_far.mem[3], mval(16'h1100));
		chk(u_far.mem[15], 16'h1235);
		wreg(rsl_pkg::REG_MODE, 16'h0000, 1'b0);
		repeat (60) @(negedge CLK_I);
		rreg(BLK, 16'h0200);
		wreg(BLK, 16'h0300, 1'b1);
		wreg(rsl_pkg::REG_INTERVAL, 16'h0001, 1'b0);
		acc(1'b0, rsl_pkg::REG_STATUS, 16'h0000);
		chk(rd & 16'h000b, 16'h000a);
		wreg(rsl_pkg::REG_ERASE, 16'h0000, 1'b0);
		chk(u_far.mem[5], 16'hffff);
		rreg(rsl_pkg::REG_PTR_LO, 16'h0000);
		wreg(BLK + 16'h0007, 16'h0001, 1'b0);
		// until full with a slow far side: sixteen words then nothing more
		dly = 4'h3;
		nwr = 0;
		wreg(rsl_pkg::REG_MODE, 16'h0002, 1'b0);
		wait_wr(16);
		repeat (150) @(negedge CLK_I);
		chk(16'(nwr), 16'h0010);
		chk(u_far.mem[2], mval(16'h0200));
		chk(u_far.mem[9], mval(16'h1100));
		rreg(rsl_pkg::REG_MODE, 16'h0000);
		acc(1'b0, rsl_pkg::REG_STATUS, 16'h0000);
		chk(rd & 16'h0007, 16'h0006);
		rreg(rsl_pkg::REG_PTR_LO, 16'h000f);
		final_report;
	end
endmodule
